// [hw/cap_sense_freq_measure.sv]
// Capacitive sensing oscillator routing, counters, gate and register slave
`timescale 1ns/100ps
module cap_sense_freq_measure #(
   parameter int NUM_INPUTS = 16,
   parameter int WDT_CYCLES = cap_sense_pkg::WDT_CYCLES
) (
   input  wire logic                  clk,
   input  wire logic                  nrst,
   input  wire logic [NUM_INPUTS-1:0] senseInputPin,
   input  wire logic                  counterAPin,
   input  wire logic                  gatePin,
   input  wire logic                  sleepMode,
   input  wire logic                  wakeEvent,
   output logic                       senseOscEnable,
   output logic [1:0]                 senseRange,
   output logic [3:0]                 senseChannel,
   input  wire logic [31:0]           awaddr,
   input  wire logic                  awvalid,
   output logic                       awready,
   input  wire logic [31:0]           wdata,
   input  wire logic [3:0]            wstrb,
   input  wire logic                  wvalid,
   output logic                       wready,
   output logic [1:0]                 bresp,
   output logic                       bvalid,
   input  wire logic                  bready,
   input  wire logic [31:0]           araddr,
   input  wire logic                  arvalid,
   output logic                       arready,
   output logic [31:0]                rdata,
   output logic [1:0]                 rresp,
   output logic                       rvalid,
   input  wire logic                  rready
);
   import cap_sense_pkg::*;

   typedef struct packed {
      wr_state_t   wst;
      rd_state_t   rst;
      logic        awHeld;
      logic        wHeld;
      logic [7:0]  awAddr;
      logic [31:0] wData;
      logic [3:0]  wStrb;
      logic        awready;
      logic        wready;
      logic [1:0]  bresp;
      logic        arready;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        senseEnable;
      logic [1:0]  senseRange;
      logic        oscSelA;
      logic [3:0]  channel;
      logic        srcSelA;
      logic [1:0]  gClkSel;
      logic        gRun;
      logic        gateEnable;
      logic        toggleMode;
      logic [1:0]  gateSrc;
      logic [7:0]  period;
      logic        periodRun;
      logic [7:0]  countA;
      logic [15:0] gCount;
      logic [7:0]  pCount;
      logic        prevOsc;
      logic        prevExtA;
      logic        gateFlop;
      logic        ovfA;
      logic        ovfP;
   } state_t;

   state_t      st;
   state_t      next_st;
   logic        tick;
   logic        wdtOvf;
   logic        oscRise;
   logic        incA;
   logic        incG;
   logic        gateEvt;
   logic        gateOpen;
   logic        gSrc;
   logic        awTake;
   logic        wTake;
   logic        wrDo;
   logic        wrA;
   logic        wrG;
   logic [7:0]  wrAddr;
   logic [31:0] wrData;
   logic [3:0]  wrStrb;
   logic [31:0] rdMux;
   logic [8:0]  sumA;

   tick_divider #(.DIV(TICK_DIV)) u_tick (
      .clk  (clk),
      .nrst (nrst),
      .tick (tick)
   );

   watchdog_timer #(.CYCLES(WDT_CYCLES)) u_wdt (
      .clk       (clk),
      .nrst      (nrst),
      .wakeEvent (wakeEvent),
      .overflow  (wdtOvf)
   );

   always_comb
   begin
      next_st = st;
      // Oscillator runs off the selected pad whenever enabled, sleep or not
      oscRise = st.senseEnable & senseInputPin[st.channel] & ~st.prevOsc;
      next_st.prevOsc = st.senseEnable & senseInputPin[st.channel];
      next_st.prevExtA = counterAPin;

      if (st.srcSelA)
         incA = counterAPin & ~st.prevExtA;
      else if (st.oscSelA)
         incA = oscRise;
      else
         incA = tick;
      incA = incA & ~sleepMode;
      sumA = {1'b0, st.countA} + {8'h00, incA};
      next_st.countA = sumA[7:0];
      next_st.ovfA = sumA[8];

      next_st.ovfP = 1'b0;
      if (tick & st.periodRun & ~sleepMode)
      begin
         next_st.ovfP = (st.pCount == st.period);
         next_st.pCount = (st.pCount == st.period) ? 8'h00 : st.pCount + 8'h01;
      end

      case (st.gateSrc)
         GSRC_CNTA: gateEvt = st.ovfA;
         GSRC_PER:  gateEvt = st.ovfP;
         GSRC_PIN:  gateEvt = gatePin;
         default:   gateEvt = wdtOvf;
      endcase
      if (!st.toggleMode)
         next_st.gateFlop = 1'b0;
      else if (gateEvt)
         next_st.gateFlop = ~st.gateFlop;
      gateOpen = st.toggleMode ? st.gateFlop : gateEvt;

      case (st.gClkSel)
         GCLK_OSC: gSrc = oscRise;
         GCLK_SYS: gSrc = ~sleepMode;
         default:  gSrc = tick & ~sleepMode;
      endcase
      incG = st.gRun & (~st.gateEnable | gateOpen) & gSrc;
      next_st.gCount = st.gCount + {15'h0000, incG};

      awTake = awvalid & st.awready;
      wTake = wvalid & st.wready;
      if (awTake)
      begin
         next_st.awHeld = 1'b1;
         next_st.awAddr = awaddr[7:0];
      end
      if (wTake)
      begin
         next_st.wHeld = 1'b1;
         next_st.wData = wdata;
         next_st.wStrb = wstrb;
      end
      wrDo = (st.awHeld | awTake) & (st.wHeld | wTake);
      wrAddr = st.awHeld ? st.awAddr : awaddr[7:0];
      wrData = st.wHeld ? st.wData : wdata;
      wrStrb = st.wHeld ? st.wStrb : wstrb;
      wrA = wrDo & (wrAddr == OFS_CNTA);
      wrG = wrDo & (wrAddr == OFS_GCNT);

      if (st.wst == W_RESP && bready)
         next_st.wst = W_IDLE;
      if (wrDo)
      begin
         next_st.awHeld = 1'b0;
         next_st.wHeld = 1'b0;
         next_st.wst = W_RESP;
         next_st.bresp = RESP_OKAY;
         // Software writes beat a same-cycle increment so a clear is exact
         case (wrAddr)
            OFS_SENSE0:
               if (wrStrb[0])
               begin
                  next_st.senseEnable = wrData[EN_BIT];
                  next_st.senseRange = wrData[RNG_LSB +: 2];
                  next_st.oscSelA = wrData[XCS_BIT];
               end
            OFS_SENSE1:
               if (wrStrb[0])
                  next_st.channel = wrData[3:0];
            OFS_OPTION:
               if (wrStrb[0])
                  next_st.srcSelA = wrData[SRCSEL_BIT];
            OFS_CNTA:
               if (wrStrb[0])
                  next_st.countA = wrData[7:0];
            OFS_GCTRL:
               if (wrStrb[0])
               begin
                  next_st.gClkSel = wrData[GCS_LSB +: 2];
                  next_st.gRun = wrData[RUN_BIT];
               end
            OFS_GATE:
               if (wrStrb[0])
               begin
                  next_st.gateEnable = wrData[GE_BIT];
                  next_st.toggleMode = wrData[GTM_BIT];
                  next_st.gateSrc = wrData[GSS_LSB +: 2];
               end
            OFS_GCNT:
            begin
               if (wrStrb[0])
                  next_st.gCount[7:0] = wrData[7:0];
               if (wrStrb[1])
                  next_st.gCount[15:8] = wrData[15:8];
            end
            OFS_PERIOD:
            begin
               if (wrStrb[0])
                  next_st.period = wrData[7:0];
               if (wrStrb[1])
                  next_st.periodRun = wrData[PRUN_BIT];
            end
            default:
               next_st.bresp = RESP_SLVERR;
         endcase
      end
      next_st.awready = (next_st.wst == W_IDLE) & ~next_st.awHeld;
      next_st.wready = (next_st.wst == W_IDLE) & ~next_st.wHeld;

      rdMux = 32'h00000000;
      case (araddr[7:0])
         OFS_SENSE0:
         begin
            rdMux[EN_BIT] = st.senseEnable;
            rdMux[RNG_LSB +: 2] = st.senseRange;
            rdMux[OUT_BIT] = st.prevOsc;
            rdMux[XCS_BIT] = st.oscSelA;
         end
         OFS_SENSE1: rdMux[3:0] = st.channel;
         OFS_OPTION: rdMux[SRCSEL_BIT] = st.srcSelA;
         OFS_CNTA:   rdMux[7:0] = st.countA;
         OFS_GCTRL:
         begin
            rdMux[GCS_LSB +: 2] = st.gClkSel;
            rdMux[RUN_BIT] = st.gRun;
         end
         OFS_GATE:
         begin
            rdMux[GE_BIT] = st.gateEnable;
            rdMux[GTM_BIT] = st.toggleMode;
            rdMux[GVAL_BIT] = gateOpen;
            rdMux[GSS_LSB +: 2] = st.gateSrc;
         end
         OFS_GCNT:   rdMux[15:0] = st.gCount;
         OFS_PERIOD:
         begin
            rdMux[7:0] = st.period;
            rdMux[PRUN_BIT] = st.periodRun;
            rdMux[PCNT_LSB +: 8] = st.pCount;
         end
         default:    rdMux = 32'h00000000;
      endcase
      case (st.rst)
         R_IDLE:
            if (arvalid)
            begin
               next_st.rst = R_DATA;
               next_st.arready = 1'b0;
               next_st.rdata = rdMux;
               next_st.rresp = (araddr[7:0] > OFS_PERIOD || araddr[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
            end
         R_DATA:
            if (rready)
            begin
               next_st.rst = R_IDLE;
               next_st.arready = 1'b1;
            end
         default:
         begin
            next_st.rst = R_IDLE;
            next_st.arready = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         st <= '0;
         st.wst <= W_IDLE;
         st.rst <= R_IDLE;
         st.awready <= 1'b1;
         st.wready <= 1'b1;
         st.arready <= 1'b1;
         st.srcSelA <= OPTION_RST;
         st.period <= PERIOD_RST;
      end
      else
         st <= next_st;
   end

   assign awready = st.awready;
   assign wready = st.wready;
   // One-hot codes: the response and data states are single flops
   assign bvalid = st.wst[1];
   assign bresp = st.bresp;
   assign arready = st.arready;
   assign rvalid = st.rst[1];
   assign rdata = st.rdata;
   assign rresp = st.rresp;
   assign senseOscEnable = st.senseEnable;
   assign senseRange = st.senseRange;
   assign senseChannel = st.channel;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   sequence wdtGateArmed;
      st.toggleMode && st.gateSrc == GSRC_WDT && wdtOvf;
   endsequence
   sequence firstOvf;
      !st.gateFlop ##0 wdtGateArmed;
   endsequence
   sequence secondOvf;
      st.gateFlop ##0 wdtGateArmed;
   endsequence

   osc_counts_a_a: assert property (
      (!st.srcSelA && st.oscSelA && oscRise && !sleepMode && !wrA) |=> st.countA == 8'($past(st.countA) + 8'h01))
      else $error("counter_a missed an oscillator cycle");
   osc_counts_g_a: assert property (
      (st.gClkSel == GCLK_OSC && st.gRun && !st.gateEnable && oscRise && !wrG)
      |=> st.gCount == 16'($past(st.gCount) + 16'h0001))
      else $error("gated counter missed an oscillator cycle");
   gated_off_a: assert property ((!st.gRun && !wrG) |=> st.gCount == $past(st.gCount))
      else $error("gated counter moved while stopped");
   gate_closed_a: assert property (
      (st.gateEnable && st.toggleMode && !st.gateFlop && !wrG) |=> st.gCount == $past(st.gCount))
      else $error("gated counter moved with gate shut");
   wdt_open_a: assert property (firstOvf |=> st.gateFlop)
      else $error("first watchdog overflow did not open gate");
   wdt_close_a: assert property (secondOvf |=> !st.gateFlop)
      else $error("second watchdog overflow did not close gate");
   sleep_stall_a: assert property ((sleepMode && !wrA) |=> st.countA == $past(st.countA))
      else $error("counter_a counted during sleep");
   one_per_cycle_a: assert property (oscRise |=> !oscRise)
      else $error("one oscillator cycle gave two counts");
   osc_disabled_a: assert property (!st.senseEnable |-> !oscRise && senseOscEnable == 1'b0)
      else $error("oscillator active while module disabled");
   write_answer_a: assert property ((awvalid && awready && wvalid && wready) |=> bvalid)
      else $error("write response missing");
endmodule : cap_sense_freq_measure

// [hw/cap_sense_pkg.sv]
// Shared constants and types of the capacitive sensing measurement block
package cap_sense_pkg;
   localparam int CLK_MHZ       = 50;
   localparam int TICK_DIV      = 4;
   localparam int WDT_PERIOD_US = 1000;
   localparam int WDT_CYCLES    = WDT_PERIOD_US * CLK_MHZ;

   localparam logic [7:0] OFS_SENSE0 = 8'h00;
   localparam logic [7:0] OFS_SENSE1 = 8'h04;
   localparam logic [7:0] OFS_OPTION = 8'h08;
   localparam logic [7:0] OFS_CNTA   = 8'h0c;
   localparam logic [7:0] OFS_GCTRL  = 8'h10;
   localparam logic [7:0] OFS_GATE   = 8'h14;
   localparam logic [7:0] OFS_GCNT   = 8'h18;
   localparam logic [7:0] OFS_PERIOD = 8'h1c;

   localparam int EN_BIT     = 7;
   localparam int RNG_LSB    = 2;
   localparam int OUT_BIT    = 1;
   localparam int XCS_BIT    = 0;
   localparam int SRCSEL_BIT = 0;
   localparam int GCS_LSB    = 6;
   localparam int RUN_BIT    = 0;
   localparam int GE_BIT     = 7;
   localparam int GTM_BIT    = 6;
   localparam int GVAL_BIT   = 2;
   localparam int GSS_LSB    = 0;
   localparam int PRUN_BIT   = 8;
   localparam int PCNT_LSB   = 16;

   localparam logic       OPTION_RST = 1'b1;
   localparam logic [7:0] PERIOD_RST = 8'hff;

   localparam logic [1:0] GCLK_TICK = 2'h0;
   localparam logic [1:0] GCLK_SYS  = 2'h1;
   localparam logic [1:0] GCLK_OSC  = 2'h3;
   localparam logic [1:0] GSRC_CNTA = 2'h0;
   localparam logic [1:0] GSRC_PER  = 2'h1;
   localparam logic [1:0] GSRC_PIN  = 2'h2;
   localparam logic [1:0] GSRC_WDT  = 2'h3;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {W_IDLE = 2'b01, W_RESP = 2'b10} wr_state_t;
   typedef enum logic [1:0] {R_IDLE = 2'b01, R_DATA = 2'b10} rd_state_t;
endpackage : cap_sense_pkg

// [hw/tick_divider.sv]
// Divider giving a one-cycle enable pulse every DIV clocks
`timescale 1ns/100ps
module tick_divider #(
   parameter int DIV = cap_sense_pkg::TICK_DIV
) (
   input  wire logic clk,
   input  wire logic nrst,
   output logic      tick
);
   import cap_sense_pkg::*;
   localparam int W = (DIV > 2) ? $clog2(DIV) : 1;
   localparam logic [W-1:0] LAST = W'(DIV - 1);

   typedef struct packed {
      logic [W-1:0] cnt;
      logic         tick;
   } div_state_t;

   div_state_t st;
   div_state_t next_st;

   always_comb
   begin
      next_st = st;
      next_st.tick = (st.cnt == LAST);
      next_st.cnt = (st.cnt == LAST) ? '0 : st.cnt + W'(1);
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         st <= '0;
      else
         st <= next_st;
   end

   assign tick = st.tick;

   tick_single_a: assert property (@(posedge clk) disable iff (!nrst) (DIV > 1 && tick) |=> !tick)
      else $error("tick lasted more than one cycle");
endmodule : tick_divider

// [hw/watchdog_timer.sv]
// Free-running watchdog period timer; an early wake restarts its period
`timescale 1ns/100ps
module watchdog_timer #(
   parameter int CYCLES = cap_sense_pkg::WDT_CYCLES
) (
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic wakeEvent,
   output logic      overflow
);
   import cap_sense_pkg::*;
   localparam int W = $clog2(CYCLES + 1);
   localparam logic [W-1:0] LAST = W'(CYCLES - 1);

   typedef struct packed {
      logic [W-1:0] cnt;
      logic         ovf;
   } wdt_state_t;

   wdt_state_t st;
   wdt_state_t next_st;

   always_comb
   begin
      next_st = st;
      next_st.ovf = 1'b0;
      if (wakeEvent)
         next_st.cnt = '0;
      else if (st.cnt == LAST)
      begin
         next_st.cnt = '0;
         next_st.ovf = 1'b1;
      end
      else
         next_st.cnt = st.cnt + W'(1);
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         st <= '0;
      else
         st <= next_st;
   end

   assign overflow = st.ovf;

   // Needs CYCLES of at least 8
   wake_delays_a: assert property (@(posedge clk) disable iff (!nrst) wakeEvent |=> !overflow [*8])
      else $error("watchdog overflow not delayed by wake");
endmodule : watchdog_timer

// [tb/cap_sense_freq_measure_test.sv]
// Self-checking bench of the capacitive sensing measurement block
`timescale 1ns/100ps
module cap_sense_freq_measure_test;
   import cap_sense_pkg::*;
   localparam int WDT = 64;
   localparam int HALF = 3;
   logic        clk;
   logic        nrst;
   logic [15:0] senseInputPin;
   logic        gatePin, sleepMode, wakeEvent, senseOscEnable, padLoad;
   logic [1:0]  senseRange;
   logic [3:0]  senseChannel;
   logic [31:0] awaddr, wdata, araddr, rdata, rd, c1, c2;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, resp;
   logic [15:0] limit, edgeCount;
   int          bad_count = 0;
   int          cmp_count = 0;
   int          cycles = 0;

   cap_sense_freq_measure #(.NUM_INPUTS(16), .WDT_CYCLES(WDT)) cap_sense_freq_measure_i (
      .clk(clk), .nrst(nrst), .senseInputPin(senseInputPin), .counterAPin(1'b0),
      .gatePin(gatePin), .sleepMode(sleepMode), .wakeEvent(wakeEvent),
      .senseOscEnable(senseOscEnable), .senseRange(senseRange), .senseChannel(senseChannel),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready));

   pad_osc_model #(.HALF(HALF)) pad_osc_model_i (
      .clk(clk), .senseOscEnable(senseOscEnable), .senseChannel(senseChannel),
      .limit(limit), .load(padLoad), .senseInputPin(senseInputPin), .edgeCount(edgeCount));

   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_of_test

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // Response ready lines stay high throughout, so no release can clash with a new request
   // No wait limit here: a hung bus is caught by the cycle ceiling
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      awaddr  <= {24'h0, a};
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      do
      begin
         @(posedge clk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
      end
      while (bvalid !== 1'b1);
      r = bresp;
   endtask : axi_write

   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr  <= {24'h0, a};
      arvalid <= 1'b1;
      do
      begin
         @(posedge clk);
         if (arready)
            arvalid <= 1'b0;
      end
      while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
   endtask : axi_read

   task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
      axi_write(a, d, resp);
      check($sformatf("write resp %h", a), 32'(resp), 32'(RESP_OKAY));
   endtask : wr_ok

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      axi_read(a, rd, resp);
      check($sformatf("reg %h", a), rd, exp);
   endtask : rd_chk

   // Burst of n full oscillator cycles on the selected pad
   task automatic osc(input int n);
      limit <= edgeCount + 16'(n);
      repeat (2 * HALF * n + 6) @(posedge clk);
   endtask : osc

   task automatic wait_gate(input logic v);
      int n;
      n = 0;
      do
      begin
         axi_read(OFS_GATE, rd, resp);
         n++;
      end
      while (rd[GVAL_BIT] !== v && n < 60);
      if (n >= 60)
         bad_count++;
   endtask : wait_gate

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Whole run needs about a thousand cycles
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         bad_count++;
         end_of_test();
      end
   end

   initial
   begin
      nrst = 1'b0;
      {padLoad, gatePin, sleepMode, wakeEvent, awvalid, wvalid, arvalid} = 7'h0;
      {bready, rready} = 2'h3;
      limit = 16'h0;
      awaddr = 32'h0;
      araddr = 32'h0;
      wdata = 32'h0;
      wstrb = 4'hf;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      rd_chk(OFS_OPTION, 32'h1);
      rd_chk(OFS_PERIOD, 32'hff);
      rd_chk(OFS_SENSE0, 32'h0);
      check("osc enable", 32'(senseOscEnable), 32'h0);
      axi_read(8'h20, rd, resp);
      check("unmapped read", {rd[29:0], resp}, 32'(RESP_SLVERR));
      axi_write(8'h22, 32'hff, resp);
      check("unmapped write", 32'(resp), 32'(RESP_SLVERR));
      wr_ok(OFS_SENSE0, 32'h8d);
      wr_ok(OFS_SENSE1, 32'h9);
      check("sense pins", {senseOscEnable, senseRange, senseChannel}, 32'h79);
      wr_ok(OFS_OPTION, 32'h0);
      wr_ok(OFS_GCTRL, 32'hc1);
      wr_ok(OFS_CNTA, 32'h0);
      wr_ok(OFS_GCNT, 32'h0);
      osc(7);
      rd_chk(OFS_CNTA, 32'h7);
      rd_chk(OFS_GCNT, 32'h7);
      sleepMode <= 1'b1;
      osc(5);
      rd_chk(OFS_CNTA, 32'h7);
      rd_chk(OFS_GCNT, 32'hc);
      sleepMode <= 1'b0;
      wr_ok(OFS_GCTRL, 32'hc0);
      osc(4);
      rd_chk(OFS_GCNT, 32'hc);
      wr_ok(OFS_GATE, 32'hc2);
      wr_ok(OFS_GCTRL, 32'hc1);
      osc(4);
      rd_chk(OFS_GCNT, 32'hc);
      gatePin <= 1'b1;
      @(posedge clk);
      gatePin <= 1'b0;
      repeat (3) @(posedge clk);
      rd_chk(OFS_GATE, 32'hc6);
      osc(5);
      gatePin <= 1'b1;
      @(posedge clk);
      gatePin <= 1'b0;
      repeat (3) @(posedge clk);
      osc(4);
      rd_chk(OFS_GCNT, 32'h11);
      rd_chk(OFS_GATE, 32'hc2);
      // Gate toggled by counter_a overflow; the opening wrap is not counted, the closing wrap is
      wr_ok(OFS_CNTA, 32'hfe);
      wr_ok(OFS_GCNT, 32'h0);
      wr_ok(OFS_GATE, 32'hc0);
      osc(2);
      osc(3);
      rd_chk(OFS_GCNT, 32'h3);
      rd_chk(OFS_GATE, 32'hc4);
      wr_ok(OFS_CNTA, 32'hff);
      osc(1);
      osc(2);
      rd_chk(OFS_GCNT, 32'h4);
      rd_chk(OFS_GATE, 32'hc0);
      // Gate toggled by period_counter overflow
      wr_ok(OFS_GATE, 32'hc1);
      wr_ok(OFS_PERIOD, 32'h103);
      wait_gate(1'b1);
      wait_gate(1'b0);
      wr_ok(OFS_PERIOD, 32'hff);
      // Sleep measurement, time base from the watchdog, never from the gated counter
      wr_ok(OFS_GCNT, 32'h0);
      wr_ok(OFS_GATE, 32'hc3);
      limit <= 16'hffff;
      sleepMode <= 1'b1;
      wait_gate(1'b1);
      wait_gate(1'b0);
      axi_read(OFS_GCNT, c1, resp);
      repeat (20) @(posedge clk);
      rd_chk(OFS_GCNT, c1);
      check("wdt window", 32'(c1 >= 32'd10 && c1 <= 32'd11), 32'h1);
      // Loaded pad measured over the same watchdog window
      padLoad <= 1'b1;
      wr_ok(OFS_GCNT, 32'h0);
      wait_gate(1'b1);
      wait_gate(1'b0);
      axi_read(OFS_GCNT, c2, resp);
      check("loaded window", c2, 32'h8);
      check("threshold", 32'(c2 < (c1 + c2) / 2 && (c1 + c2) / 2 < c1), 32'h1);
      padLoad <= 1'b0;
      wr_ok(OFS_GCNT, 32'h0);
      wait_gate(1'b1);
      repeat (30) @(posedge clk);
      wakeEvent <= 1'b1;
      @(posedge clk);
      wakeEvent <= 1'b0;
      wait_gate(1'b0);
      axi_read(OFS_GCNT, c1, resp);
      check("wake window", 32'(c1 > 32'd12), 32'h1);
      limit <= 16'h0;
      sleepMode <= 1'b0;
      repeat (10) @(posedge clk);
      end_of_test();
   end
endmodule : cap_sense_freq_measure_test

// [tb/pad_osc_model.sv]
// Touch pad board model: oscillator wave on the selected pad, restless idle pads
`timescale 1ns/100ps
module pad_osc_model #(
   parameter int HALF = 3
) (
   input  wire logic        clk,
   input  wire logic        senseOscEnable,
   input  wire logic [3:0]  senseChannel,
   input  wire logic [15:0] limit,
   input  wire logic        load,
   output logic [15:0]      senseInputPin,
   output logic [15:0]      edgeCount
);
   logic       wave = 1'b0;
   logic       noise = 1'b0;
   logic [7:0] phase = 8'h0;
   logic [15:0] edges = 16'h0;

   assign edgeCount = edges;

   // Idle pads never sit still, so a wrong channel pick shows up as stray counts
   always_comb
   begin
      senseInputPin = {16{noise}};
      senseInputPin[senseChannel] = wave;
   end

   // No sleep input: the wave runs whenever enabled; the bench limit only ends a burst
   always @(posedge clk)
   begin
      noise <= ~noise;
      if (!senseOscEnable || (edges >= limit && !wave))
      begin
         wave  <= 1'b0;
         phase <= 8'h0;
      end
      // A finger load stretches each half cycle by one clock
      else if (phase == (load ? 8'(HALF) : 8'(HALF - 1)))
      begin
         phase <= 8'h0;
         wave  <= ~wave;
         if (!wave)
            edges <= edges + 16'h1;
      end
      else
         phase <= phase + 8'h1;
   end
endmodule : pad_osc_model
